// ### design/dwscp_pkg.sv
// dwscp_pkg: word layout, command codes, store map, reset values and link timing
// for the dual wiper serial command port.
// assumes: both ends and the bench share these constants; nothing is imported.
package dwscp_pkg;

	// serial word layout
	localparam int unsigned WORD_BITS   = 24;
	localparam logic [5:0]  FRAME_ONE   = 6'h18;    // bits in one word
	localparam logic [5:0]  FRAME_TWO   = 6'h30;    // bits in a two-device chain frame
	localparam int unsigned CMD_MSB     = 23;
	localparam int unsigned CMD_LSB     = 20;
	localparam int unsigned ADDR_MSB    = 19;
	localparam int unsigned ADDR_LSB    = 16;
	localparam int unsigned DATA_MSB    = 15;
	localparam int unsigned DATA_LSB    = 0;

	// command codes
	localparam logic [3:0] CMD_NO_OPERATION   = 4'h0;
	localparam logic [3:0] CMD_RESTORE_ONE    = 4'h1;
	localparam logic [3:0] CMD_SAVE_WIPER     = 4'h2;
	localparam logic [3:0] CMD_STORE_USER     = 4'h3;
	localparam logic [3:0] CMD_RESTORE_ALL    = 4'h8;
	localparam logic [3:0] CMD_READ_STORE     = 4'h9;
	localparam logic [3:0] CMD_READ_WIPER     = 4'hA;
	localparam logic [3:0] CMD_WRITE_WIPER    = 4'hB;

	// wiper and store geometry
	localparam int unsigned WIPER_BITS      = 10;
	localparam int unsigned TAP_COUNT       = 1024;
	localparam int unsigned NV_WORDS        = 16;
	localparam logic [3:0]  USER_FIRST_ADDR = 4'h2;
	localparam logic [3:0]  USER_LAST_ADDR  = 4'hE;
	localparam logic [3:0]  FACTORY_ADDR    = 4'hF;

	// values after reset
	localparam logic [9:0]  WIPER_RESET     = 10'h000;
	localparam logic [15:0] NV_WIPER_RESET  = 16'h0200;
	localparam logic [15:0] NV_USER_RESET   = 16'h0000;
	localparam logic [15:0] FACTORY_WORD    = 16'h0000;  // arbitrary value
	localparam logic [23:0] SHIFT_RESET     = 24'h000000;

	// link timing
	localparam int unsigned CLOCK_PERIOD_NS   = 8;
	localparam int unsigned SCLK_PERIOD_NS    = 80;
	localparam logic [2:0]  SCLK_HALF_CYCLES  = 3'(SCLK_PERIOD_NS / (2 * CLOCK_PERIOD_NS));

	// field extraction
	function automatic logic [3:0] field_command(input logic [23:0] word);
		field_command = word[CMD_MSB:CMD_LSB];
	endfunction : field_command

	function automatic logic [3:0] field_address(input logic [23:0] word);
		field_address = word[ADDR_MSB:ADDR_LSB];
	endfunction : field_address

	function automatic logic [15:0] field_data(input logic [23:0] word);
		field_data = word[DATA_MSB:DATA_LSB];
	endfunction : field_data

endpackage : dwscp_pkg

// ### design/dwscp_link_if.sv
// dwscp_link_if: the serial link between host master and device port.
// assumes: one host and one device per instance; chains use one instance per hop.
`timescale 1ns/10ps
`default_nettype none
interface dwscp_link_if;
	// host driven wires
	logic sclk;
	logic cs_n;
	logic serial_in;
	logic preset_strobe_n;
	logic write_protect_n;
	// open-drain output of the device
	logic sdo_out;
	logic sdo_oe;
	logic serial_out_open_drain;

	// pull-up wins unless the device pulls low
	assign serial_out_open_drain = !(sdo_oe && !sdo_out);

	modport device (
		input  sclk, cs_n, serial_in, preset_strobe_n, write_protect_n,
		output sdo_out, sdo_oe
	);
	modport host (
		output sclk, cs_n, serial_in, preset_strobe_n, write_protect_n,
		input  serial_out_open_drain
	);
endinterface : dwscp_link_if
`default_nettype wire

// ### design/dwscp_tap_decoder.sv
// dwscp_tap_decoder: registered one-hot decode of a wiper code onto the tap switches.
// assumes: code comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module dwscp_tap_decoder (
	// system
	input  wire logic        clock,
	input  wire logic        clk_en,
	input  wire logic        rst_b,
	// code in
	input  wire logic [9:0]  code,
	// switches out
	output logic      [1023:0] tap_switch,
	output logic             common_switch_on
);
	localparam logic [dwscp_pkg::TAP_COUNT-1:0] TAP_ONE = {{(dwscp_pkg::TAP_COUNT-1){1'b0}}, 1'b1};

	// code zero is the bottom tap, each step one tap up
	wire logic [1023:0] next_tap_switch = TAP_ONE << code;

	// exactly one tap on from reset onward, common switch always on
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			tap_switch       <= TAP_ONE;
			common_switch_on <= 1'b1;
		end
		else if (clk_en)
		begin
			tap_switch       <= next_tap_switch;
			common_switch_on <= 1'b1;
		end
	end
endmodule : dwscp_tap_decoder
`default_nettype wire

// ### design/dwscp_device_end.sv
// dwscp_device_end: serial command port, wiper registers and word store of the
// dual wiper resistor, on the device side of the link.
// assumes: link pins are asynchronous to clock and are synchronised here; the host
// runs the link clock at least four clock cycles per half period.
`timescale 1ns/10ps
`default_nettype none
module dwscp_device_end (
	// system
	input  wire logic          clock,
	input  wire logic          clk_en,
	input  wire logic          rst_b,
	// serial link
	dwscp_link_if.device       link,
	// wiper codes
	output logic      [9:0]    wiper_code_0,
	output logic      [9:0]    wiper_code_1,
	// resistor switches
	output logic      [1023:0] tap_switch_0,
	output logic      [1023:0] tap_switch_1,
	output logic               common_switch_on_0,
	output logic               common_switch_on_1
);
	// two-flop synchronisers, only bit 1 is read
	logic [1:0] sclk_sync;
	logic [1:0] cs_sync;
	logic [1:0] sdi_sync;
	logic [1:0] preset_sync;
	logic [1:0] protect_sync;
	logic       sclk_prev;
	logic       cs_prev;

	// port state
	logic [23:0] shift_word;
	logic [5:0]  bit_count;
	logic        sdo_bit;
	logic        sdo_oe_reg;
	logic        power_on_pending;
	logic [9:0]  wiper_code_register [2];
	logic [15:0] nonvolatile_word_store [dwscp_pkg::NV_WORDS];

	// pins sampled into the clock domain
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			sclk_sync    <= 2'h0;
			cs_sync      <= 2'h3;
			sdi_sync     <= 2'h0;
			preset_sync  <= 2'h3;
			protect_sync <= 2'h3;
			sclk_prev    <= 1'b0;
			cs_prev      <= 1'b1;
		end
		else if (clk_en)
		begin
			sclk_sync    <= {sclk_sync[0], link.sclk};
			cs_sync      <= {cs_sync[0], link.cs_n};
			sdi_sync     <= {sdi_sync[0], link.serial_in};
			preset_sync  <= {preset_sync[0], link.preset_strobe_n};
			protect_sync <= {protect_sync[0], link.write_protect_n};
			sclk_prev    <= sclk_sync[1];
			cs_prev      <= cs_sync[1];
		end
	end

	// edges of the synchronised link signals
	wire logic selected   = !cs_sync[1];
	wire logic sclk_rise  = sclk_sync[1] && !sclk_prev && selected;
	wire logic sclk_fall  = !sclk_sync[1] && sclk_prev && selected;
	wire logic cs_fall    = !cs_sync[1] && cs_prev;
	wire logic cs_rise    = cs_sync[1] && !cs_prev;
	wire logic preset_on  = !preset_sync[1];
	wire logic protect_on = !protect_sync[1];

	// decode of the word held when select rises
	wire logic [3:0]  word_cmd   = dwscp_pkg::field_command(shift_word);
	wire logic [3:0]  word_addr  = dwscp_pkg::field_address(shift_word);
	wire logic [15:0] word_data  = dwscp_pkg::field_data(shift_word);
	wire logic        word_chan  = word_addr[0];
	wire logic        full_word  = bit_count == dwscp_pkg::FRAME_ONE;
	wire logic        execute    = cs_rise && full_word;
	wire logic        do_restore_one  = execute && word_cmd == dwscp_pkg::CMD_RESTORE_ONE;
	wire logic        do_restore_all  = execute && word_cmd == dwscp_pkg::CMD_RESTORE_ALL;
	wire logic        do_write_wiper  = execute && word_cmd == dwscp_pkg::CMD_WRITE_WIPER;
	wire logic        do_save_wiper   = execute && word_cmd == dwscp_pkg::CMD_SAVE_WIPER && !protect_on;
	wire logic        user_addr_ok    = word_addr >= dwscp_pkg::USER_FIRST_ADDR &&
	                                    word_addr <= dwscp_pkg::USER_LAST_ADDR;
	wire logic        do_store_user   = execute && word_cmd == dwscp_pkg::CMD_STORE_USER &&
	                                    user_addr_ok && !protect_on;
	wire logic        do_read_store   = execute && word_cmd == dwscp_pkg::CMD_READ_STORE;
	wire logic        do_read_wiper   = execute && word_cmd == dwscp_pkg::CMD_READ_WIPER;
	wire logic        restore_both    = power_on_pending || preset_on || do_restore_all;

	// readback word keeps command and address, data in the last sixteen bits
	wire logic [15:0] read_data = do_read_wiper ? {6'h00, wiper_code_register[word_chan]}
	                                            : nonvolatile_word_store[word_addr];
	wire logic [23:0] read_word = {word_cmd, word_addr, read_data};

	// shift register: msb first in, previous word falls out for the next device
	wire logic [23:0] next_shift_word = (do_read_store || do_read_wiper) ? read_word
	                                  : sclk_rise ? {shift_word[22:0], sdi_sync[1]}
	                                  : shift_word;
	wire logic [5:0]  next_bit_count  = cs_fall ? 6'h00
	                                  : (sclk_rise && !full_word) ? bit_count + 6'h01
	                                  : bit_count;
	wire logic        next_sdo_bit    = (cs_fall || sclk_fall) ? shift_word[23] : sdo_bit;
	wire logic        next_sdo_oe     = selected && !next_sdo_bit;

	// link state
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			shift_word <= dwscp_pkg::SHIFT_RESET;
			bit_count  <= 6'h00;
			sdo_bit    <= 1'b1;
			sdo_oe_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			shift_word <= next_shift_word;
			bit_count  <= next_bit_count;
			sdo_bit    <= next_sdo_bit;
			sdo_oe_reg <= next_sdo_oe;
		end
	end

	assign link.sdo_out = 1'b0;  // open drain only ever pulls low
	assign link.sdo_oe  = sdo_oe_reg;

	// next wiper codes: restores win over a write in the same cycle
	logic [9:0]  next_wiper [2];
	logic [15:0] next_store [dwscp_pkg::NV_WORDS];
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_wiper
			assign next_wiper[gi] =
				(restore_both || (do_restore_one && word_chan == 1'(gi)))
					? nonvolatile_word_store[gi][9:0]
				: (do_write_wiper && word_chan == 1'(gi)) ? word_data[9:0]
				: wiper_code_register[gi];
		end
		for (gi = 0; gi < dwscp_pkg::NV_WORDS; gi++)
		begin : g_store
			assign next_store[gi] =
				(do_store_user && word_addr == 4'(gi)) ? word_data
				: (do_save_wiper && gi < 2 && word_chan == 1'(gi))
					? {6'h00, wiper_code_register[word_chan]}
				: nonvolatile_word_store[gi];
		end
	endgenerate

	// wiper registers and power-on restore flag
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			power_on_pending       <= 1'b1;
			wiper_code_register[0] <= dwscp_pkg::WIPER_RESET;
			wiper_code_register[1] <= dwscp_pkg::WIPER_RESET;
		end
		else if (clk_en)
		begin
			power_on_pending       <= 1'b0;
			wiper_code_register[0] <= next_wiper[0];
			wiper_code_register[1] <= next_wiper[1];
		end
	end

	// word store; the factory word never takes a write
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < dwscp_pkg::NV_WORDS; i++)
			begin
				nonvolatile_word_store[i] <= (i < 2) ? dwscp_pkg::NV_WIPER_RESET : dwscp_pkg::NV_USER_RESET;
			end
			nonvolatile_word_store[dwscp_pkg::FACTORY_ADDR] <= dwscp_pkg::FACTORY_WORD;
		end
		else if (clk_en)
		begin
			for (int i = 0; i < dwscp_pkg::NV_WORDS; i++)
			begin
				nonvolatile_word_store[i] <= next_store[i];
			end
		end
	end

	assign wiper_code_0 = wiper_code_register[0];
	assign wiper_code_1 = wiper_code_register[1];

	// tap decode per channel
	dwscp_tap_decoder u_decode_0 (
		.clock            (clock),
		.clk_en           (clk_en),
		.rst_b            (rst_b),
		.code             (wiper_code_register[0]),
		.tap_switch       (tap_switch_0),
		.common_switch_on (common_switch_on_0)
	);

	dwscp_tap_decoder u_decode_1 (
		.clock            (clock),
		.clk_en           (clk_en),
		.rst_b            (rst_b),
		.code             (wiper_code_register[1]),
		.tap_switch       (tap_switch_1),
		.common_switch_on (common_switch_on_1)
	);
endmodule : dwscp_device_end
`default_nettype wire

// ### design/dwscp_host_end.sv
// dwscp_host_end: serial master that frames one or two words onto the link and
// collects what comes back on the open-drain line.
// assumes: user side on the same clock; the link clock is made here by a divider.
`timescale 1ns/10ps
`default_nettype none
module dwscp_host_end (
	// system
	input  wire logic        clock,
	input  wire logic        clk_en,
	input  wire logic        rst_b,
	// serial link
	dwscp_link_if.host       link,
	// frame request
	input  wire logic        start,
	input  wire logic        two_words,
	input  wire logic        use_mode3,
	input  wire logic [47:0] tx_word,
	// static pin levels
	input  wire logic        preset_request_n,
	input  wire logic        write_protect_request_n,
	// frame answer
	output logic             busy,
	output logic             done,
	output logic      [47:0] rx_word
);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_END, ST_GAP} dwscp_host_state_type;

	dwscp_host_state_type state;
	logic [1:0]  sdo_sync;
	logic [2:0]  half_count;
	logic [5:0]  bits_done;
	logic [5:0]  bits_total;
	logic [47:0] tx_shift;
	logic        cpol;
	logic        sclk_reg;
	logic        cs_n_reg;
	logic        preset_reg;
	logic        protect_reg;

	// divider tick every half period of the link clock
	wire logic tick       = half_count == dwscp_pkg::SCLK_HALF_CYCLES - 3'h1;
	wire logic last_bit   = bits_done == bits_total;
	wire logic take_bit   = state == ST_RUN && tick && sclk_reg && bits_done != 6'h00;
	wire logic [47:0] load_word = two_words ? tx_word : {tx_word[23:0], 24'h000000};

	// line level into the clock domain
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			sdo_sync <= 2'h3;
		end
		else if (clk_en)
		begin
			sdo_sync <= {sdo_sync[0], link.serial_out_open_drain};
		end
	end

	// frame sequencer
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			state       <= ST_IDLE;
			half_count  <= 3'h0;
			bits_done   <= 6'h00;
			bits_total  <= dwscp_pkg::FRAME_ONE;
			tx_shift    <= 48'h000000000000;
			rx_word     <= 48'h000000000000;
			cpol        <= 1'b0;
			sclk_reg    <= 1'b0;
			cs_n_reg    <= 1'b1;
			busy        <= 1'b0;
			done        <= 1'b0;
			preset_reg  <= 1'b1;
			protect_reg <= 1'b1;
		end
		else if (clk_en)
		begin
			done        <= 1'b0;
			preset_reg  <= preset_request_n;
			protect_reg <= write_protect_request_n;
			half_count  <= (state == ST_IDLE || tick) ? 3'h0 : half_count + 3'h1;
			if (take_bit)
			begin
				rx_word <= {rx_word[46:0], sdo_sync[1]};
			end
			unique case (state)
				ST_IDLE:
				begin
					// idle level set a cycle before select falls, so a mode change makes no edge in the frame
					if (start)
					begin
						state      <= ST_RUN;
						sclk_reg   <= use_mode3;
						cpol       <= use_mode3;
						busy       <= 1'b1;
						bits_done  <= 6'h00;
						bits_total <= two_words ? dwscp_pkg::FRAME_TWO : dwscp_pkg::FRAME_ONE;
						tx_shift   <= load_word;
					end
				end
				ST_RUN:
				begin
					cs_n_reg <= 1'b0;
					if (tick && !sclk_reg)
					begin
						sclk_reg  <= 1'b1;
						bits_done <= bits_done + 6'h01;
					end
					else if (tick && last_bit)
					begin
						sclk_reg <= cpol;
						state    <= ST_END;
					end
					else if (tick)
					begin
						sclk_reg <= 1'b0;
						if (bits_done != 6'h00)
						begin
							tx_shift <= {tx_shift[46:0], 1'b0};
						end
					end
				end
				ST_END:
				begin
					if (tick)
					begin
						cs_n_reg <= 1'b1;
						state    <= ST_GAP;
					end
				end
				ST_GAP:
				begin
					if (tick)
					begin
						busy  <= 1'b0;
						done  <= 1'b1;
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// link drive straight from registers
	assign link.sclk            = sclk_reg;
	assign link.cs_n            = cs_n_reg;
	assign link.serial_in       = tx_shift[47];
	assign link.preset_strobe_n = preset_reg;
	assign link.write_protect_n = protect_reg;
endmodule : dwscp_host_end
`default_nettype wire

// ### testbench/dwscp_link_props.sv
// dwscp_link_props: timing checks on the wires of the link between host and near device.
// assumes: instantiated in tb_top beside the link, on the system clock and reset.
`timescale 1ns/10ps
`default_nettype none
module dwscp_link_props (
	// system
	input wire logic clock,
	input wire logic rst_b,
	// link wires
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic preset_strobe_n,
	input wire logic write_protect_n,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic serial_out_open_drain
);
	logic [5:0] bit_count;  // link clock rises seen inside a frame

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// count rising link clock edges once the frame is open; saturates
	always_ff @(posedge clock)
	begin
		if (!rst_b || cs_n)
			bit_count <= 6'h00;
		else if ($rose(sclk) && !$past(cs_n) && bit_count != 6'h3F)
			bit_count <= bit_count + 6'h01;
	end

	// frame edges
	sequence s_frame_open;
		$fell(cs_n);
	endsequence
	sequence s_frame_close;
		$rose(cs_n);
	endsequence

	// output side and framing checks
	a_release_when_idle: assert property (cs_n [*6] |-> !sdo_oe && serial_out_open_drain)
		else $error("serial output pulled while deselected");
	a_oe_drops_late: assert property (s_frame_close |-> ##[1:5] !sdo_oe)
		else $error("serial output not released after frame");
	a_oe_only_selected: assert property ($rose(sdo_oe) |-> !cs_n)
		else $error("serial output enabled outside a frame");
	a_select_held: assert property (s_frame_open |-> !cs_n [*8])
		else $error("select released early");
	a_link_still_idle: assert property (cs_n && $past(cs_n) && $changed(sclk) |=> !cs_n)
		else $error("link clock moved between frames");
	a_data_settled: assert property ($rose(sclk) && !$past(cs_n) |-> $stable(serial_in))
		else $error("serial data changed on sampling edge");
	a_first_edge_soon: assert property (s_frame_open |-> ##[0:12] $changed(sclk))
		else $error("link clock did not start");
	a_whole_words: assert property (s_frame_close |-> bit_count == 6'h18 || bit_count == 6'h30)
		else $error("frame not a whole number of words");
endmodule : dwscp_link_props
`default_nettype wire

// ### testbench/tb_top.sv
// tb_top: host end drives the near device; a far device hangs off its serial output.
// assumes: package, link interface and both design ends are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	localparam logic [9:0]    MID = dwscp_pkg::NV_WIPER_RESET[9:0];
	localparam logic [1023:0] ONE = 1024'h1;
	localparam logic [23:0]   WORDS [17] = '{24'hB0F100, 24'hB33FFF, 24'hA00000, 24'h000000, 24'h32AAAA,
		24'h3F1234, 24'h315555, 24'h920000, 24'h9F0000, 24'h910000, 24'hA10000, 24'h000000,
		24'h100000, 24'h331111, 24'h930000, 24'h000000, 24'h800000};
	localparam logic [23:0]   ECHO [17] = '{24'h000000, 24'hB0F100, 24'hB33FFF, 24'hA00100, 24'h000000,
		24'h32AAAA, 24'h3F1234, 24'h315555, 24'h92AAAA, 24'h9F0000, 24'h910200, 24'hA103FF,
		24'h000000, 24'h100000, 24'h331111, 24'h930000, 24'h000000};
	logic          clock;
	logic          rst_b;
	logic          start;
	logic          two_words;
	logic          use_mode3;
	logic [47:0]   tx_word;
	logic          preset_n;
	logic          protect_n;
	logic          busy;
	logic          done;
	logic [47:0]   rx_word;
	logic [9:0]    wiper_0;
	logic [9:0]    wiper_1;
	logic [9:0]    far_wiper_0;
	logic [1023:0] tap_0;
	logic [1023:0] tap_1;
	logic          common_0;
	logic          common_1;
	int            err_count;
	int            n_compared;
	int            cycle_count;
	int            i;

	dwscp_link_if link_near ();
	dwscp_link_if link_far ();

	// far device shares select and clock, takes the near device's resolved output
	assign link_far.sclk            = link_near.sclk;
	assign link_far.cs_n            = link_near.cs_n;
	assign link_far.serial_in       = link_near.serial_out_open_drain;
	assign link_far.preset_strobe_n = link_near.preset_strobe_n;
	assign link_far.write_protect_n = link_near.write_protect_n;

	dwscp_host_end i_dwscp_host_end (.clock(clock), .clk_en(1'b1), .rst_b(rst_b), .link(link_near.host),
		.start(start), .two_words(two_words), .use_mode3(use_mode3), .tx_word(tx_word),
		.preset_request_n(preset_n), .write_protect_request_n(protect_n), .busy(busy), .done(done),
		.rx_word(rx_word));
	dwscp_device_end i_dwscp_device_end (.clock(clock), .clk_en(1'b1), .rst_b(rst_b),
		.link(link_near.device), .wiper_code_0(wiper_0), .wiper_code_1(wiper_1), .tap_switch_0(tap_0),
		.tap_switch_1(tap_1), .common_switch_on_0(common_0), .common_switch_on_1(common_1));
	dwscp_device_end i_dwscp_device_end_far (.clock(clock), .clk_en(1'b1), .rst_b(rst_b),
		.link(link_far.device), .wiper_code_0(far_wiper_0), .wiper_code_1(), .tap_switch_0(),
		.tap_switch_1(), .common_switch_on_0(), .common_switch_on_1());
	dwscp_link_props i_dwscp_link_props (.clock(clock), .rst_b(rst_b), .sclk(link_near.sclk),
		.cs_n(link_near.cs_n), .serial_in(link_near.serial_in), .preset_strobe_n(link_near.preset_strobe_n),
		.write_protect_n(link_near.write_protect_n), .sdo_out(link_near.sdo_out),
		.sdo_oe(link_near.sdo_oe), .serial_out_open_drain(link_near.serial_out_open_drain));

	// system clock
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// verdict and end of run
	task final_report;
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// one frame through the host end, then a few cycles for the device to act
	task automatic send_frame(input logic mode3, input logic two, input logic [47:0] word);
		int unsigned wait_count;
		@(posedge clock);
		#1 start = 1'b1;
		use_mode3 = mode3;
		two_words = two;
		tx_word = word;
		@(posedge clock);
		#1 start = 1'b0;
		`CHK("busy", 1'b1, busy)
		wait_count = 0;
		while (done !== 1'b1 && wait_count < 1000)
		begin
			@(posedge clock);
			#1 wait_count++;
		end
		if (wait_count >= 1000)
			`CHK("done", 1'b1, done)
		repeat (4) @(posedge clock);
		#1;
	endtask : send_frame

	// hang guard
	always @(posedge clock)
	begin
		cycle_count++;
		if (cycle_count == 20000)
		begin
			err_count++;
			final_report();
		end
	end

	// main sequence
	initial
	begin
		rst_b = 1'b0;
		start = 1'b0;
		two_words = 1'b0;
		use_mode3 = 1'b0;
		tx_word = 48'h0;
		preset_n = 1'b1;
		protect_n = 1'b1;
		err_count = 0;
		n_compared = 0;
		cycle_count = 0;
		repeat (20) @(posedge clock);
		#1 rst_b = 1'b1;
		repeat (6) @(posedge clock);
		#1;
		`CHK("wiper_code_0", MID, wiper_0)
		`CHK("wiper_code_1", MID, wiper_1)
		`CHK("tap_switch_0", ONE << 512, tap_0)
		`CHK("common_switch_on_0", 1'b1, common_0)
		// alternate both clock modes through the command table
		for (i = 0; i < 17; i++)
		begin
			protect_n = (i != 13);
			send_frame(i[0], 1'b0, {24'h0, WORDS[i]});
			if (i > 0)
				`CHK("rx_word", ECHO[i], rx_word[23:0])
			if (i == 11)
			begin
				`CHK("wiper_code_0", 10'h100, wiper_0)
				`CHK("wiper_code_1", 10'h3FF, wiper_1)
				`CHK("tap_switch_0", ONE << 256, tap_0)
				`CHK("tap_switch_1", ONE << 1023, tap_1)
				`CHK("common_switch_on_1", 1'b1, common_1)
			end
			if (i == 12)
				`CHK("wiper_code_0", MID, wiper_0)
		end
		`CHK("wiper_code_1", MID, wiper_1)
		// preset strobe held low pulls both wipers back to the stored codes
		send_frame(1'b0, 1'b0, 48'h000000B00055);
		`CHK("wiper_code_0", 10'h055, wiper_0)
		preset_n = 1'b0;
		repeat (12) @(posedge clock);
		#1 preset_n = 1'b1;
		repeat (8) @(posedge clock);
		#1;
		`CHK("wiper_code_0", MID, wiper_0)
		// save a written code, overwrite it, then bring it back from the store
		send_frame(1'b1, 1'b0, 48'h000000B00077);
		send_frame(1'b0, 1'b0, 48'h000000200000);
		send_frame(1'b1, 1'b0, 48'h000000B00011);
		`CHK("wiper_code_0", 10'h011, wiper_0)
		send_frame(1'b0, 1'b0, 48'h000000100000);
		`CHK("wiper_code_0", 10'h077, wiper_0)
		// two words in one frame: first word ends in the far device
		send_frame(1'b1, 1'b1, {24'hB00123, 24'hB10321});
		`CHK("rx_word", {24'h100000, 24'hB00123}, rx_word)
		`CHK("far_wiper_code_0", 10'h123, far_wiper_0)
		`CHK("wiper_code_1", 10'h321, wiper_1)
		`CHK("wiper_code_0", 10'h077, wiper_0)
		// closing no-operation word brings back the near device's last word
		send_frame(1'b0, 1'b0, 48'h000000000000);
		`CHK("rx_word", 24'hB10321, rx_word[23:0])
		final_report();
	end
endmodule : tb_top
`default_nettype wire
